/* design/hfpa_pkg.sv */
// Constants, field layouts and carrier types for the host FIFO port access block.
package hfpa_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
    localparam int HALF_W = 16;

    // Byte addresses; each data port spans eight dword aliases.
    localparam logic [7:0] RXD_BASE = 8'h00;
    localparam logic [7:0] TXD_BASE = 8'h20;
    localparam int ALIAS_LSB = 5;
    localparam logic [7:0] RXS_POP = 8'h40;
    localparam logic [7:0] RXS_PEEK = 8'h44;
    localparam logic [7:0] TXS_POP = 8'h48;
    localparam logic [7:0] TXS_PEEK = 8'h4C;
    localparam logic [7:0] STAT_ADDR = 8'h50;
    localparam logic [7:0] CFG_ADDR = 8'h54;
    localparam logic [7:0] CMD_ADDR = 8'h58;

    // Status register fields.
    localparam int STAT_TXOVR_BIT = 0;
    localparam int STAT_RXUND_BIT = 1;
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_EVT_BIT = 3;
    localparam int STAT_RXS_CNT_LSB = 8;
    localparam int STAT_TXD_CNT_LSB = 16;
    localparam int STAT_DROP_LSB = 24;
    localparam int DROP_W = 8;

    // Configuration register fields.
    localparam int CFG_SCRATCH_LSB = 0;
    localparam int CFG_KEEP_LSB = 8;
    localparam int CFG_FIELD_W = 8;
    localparam int CFG_BUS16_BIT = 16;

    // Command register fields.
    localparam int CMD_SRST_BIT = 0;
    localparam int CMD_FLUSH_BIT = 1;

    // Reset values.
    localparam logic [7:0] CFG_SCRATCH_RST = 8'h00;
    localparam logic [7:0] CFG_KEEP_RST = 8'h00;
    localparam logic CFG_BUS16_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic LINK_LL_RST = 1'b0;
    localparam logic [7:0] DROP_RST = 8'h00;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hfpa_hreq_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } hfpa_word_t;

endpackage : hfpa_pkg

/* design/hfpa_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module hfpa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = count_reg != (PTR_W + 1)'(DEPTH);
    assign out_valid_o = count_reg != '0;
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign count_o = count_reg;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_ready_i & out_valid_o;

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (ce_i) begin
            if (flush_i) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= '0;
            end else begin
                if (push) begin
                    wr_ptr_reg <= wr_ptr_reg + 1'b1;
                end
                if (pop) begin
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                end
                if (push && !pop) begin
                    count_reg <= count_reg + 1'b1;
                end else if (pop && !push) begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end

endmodule : hfpa_fifo

/* design/hfpa_top.sv */
// Host access to the four FIFO ports and the attribute register set.
`timescale 1ns/1ps
module hfpa_top
    import hfpa_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [ADDR_W-1:0] host_addr_i,
    input wire logic [DATA_W-1:0] host_wdata_i,
    output logic [DATA_W-1:0] host_rdata_o,
    output logic host_data_oe_n_o,
    output logic host_ack_o,
    output logic host_tx_ready_o,
    output logic bus16_o,
    input wire logic link_up_i,
    input wire logic mac_event_i,
    input wire hfpa_word_t rx_sts_i,
    output logic rx_sts_ready_o,
    input wire hfpa_word_t rx_dat_i,
    output logic rx_dat_ready_o,
    input wire hfpa_word_t tx_sts_i,
    output logic tx_sts_ready_o,
    output hfpa_word_t tx_dat_o,
    input wire logic tx_dat_ready_i
);
    logic [ADDR_W+DATA_W+2:0] pins_s1_reg;
    logic [ADDR_W+DATA_W+2:0] pins_s2_reg;
    hfpa_hreq_t req_s2;
    hfpa_hreq_t last_reg;
    logic rd_go;
    logic wr_go;
    logic [ADDR_W-1:0] word_addr;
    logic half_hi;
    logic word_done;
    logic wr_en;
    logic is_rxd;
    logic is_txd;
    logic [HALF_W-1:0] hold_reg;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] rdata_reg;
    logic ack_reg;
    logic drive_reg;
    logic srst_reg;
    logic flush_reg;
    logic rst_all;
    logic [CFG_FIELD_W-1:0] scratch_reg;
    logic [CFG_FIELD_W-1:0] keep_reg;
    logic bus16_reg;
    logic txovr_reg;
    logic rxund_reg;
    logic link_ll_reg;
    logic evt_lh_reg;
    logic [DROP_W-1:0] drop_reg;
    logic stat_rd;
    logic stat_wr;
    logic cfg_wr;
    logic cmd_wr;
    logic rxs_pop;
    logic rxd_pop;
    logic txs_pop;
    logic txd_push;
    logic rxs_valid;
    logic rxd_valid;
    logic txs_valid;
    logic txd_in_ready;
    logic drop_evt;
    logic [DATA_W-1:0] rxs_head;
    logic [DATA_W-1:0] rxd_head;
    logic [DATA_W-1:0] txs_head;
    logic [CNT_W-1:0] rxs_cnt;
    logic [CNT_W-1:0] txd_cnt;

    assign req_s2.rd = ~pins_s2_reg[ADDR_W+DATA_W+2] & ~pins_s2_reg[ADDR_W+DATA_W+1];
    assign req_s2.wr = ~pins_s2_reg[ADDR_W+DATA_W+2] & ~pins_s2_reg[ADDR_W+DATA_W];
    assign req_s2.addr = pins_s2_reg[DATA_W +: ADDR_W];
    assign req_s2.wdata = pins_s2_reg[DATA_W-1:0];

    // Raw pins pass two flops at their idle level; the third stage finds strobe edges.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pins_s1_reg <= '1;
            pins_s2_reg <= '1;
            last_reg <= '0;
        end else if (ce_i) begin
            pins_s1_reg <= {host_cs_n_i, host_rd_n_i, host_wr_n_i, host_addr_i, host_wdata_i};
            pins_s2_reg <= pins_s1_reg;
            last_reg <= req_s2;
        end
    end

    assign rd_go = ce_i & req_s2.rd & ~last_reg.rd;
    assign wr_go = ce_i & req_s2.wr & ~last_reg.wr;
    assign word_addr = {req_s2.addr[ADDR_W-1:2], 2'b00};
    assign half_hi = req_s2.addr[1];
    // In 16-bit mode a dword completes on its upper half.
    assign word_done = ~bus16_reg | half_hi;
    assign wr_en = wr_go & word_done;
    assign rst_all = sys_rst_i | srst_reg;

    assign is_rxd = req_s2.addr[ADDR_W-1:ALIAS_LSB] == RXD_BASE[ADDR_W-1:ALIAS_LSB];
    assign is_txd = req_s2.addr[ADDR_W-1:ALIAS_LSB] == TXD_BASE[ADDR_W-1:ALIAS_LSB];

    assign rxd_pop = rd_go & is_rxd & word_done;
    assign rxs_pop = rd_go & (word_addr == RXS_POP) & word_done;
    assign txs_pop = rd_go & (word_addr == TXS_POP) & word_done;
    assign txd_push = wr_en & is_txd;
    assign stat_rd = rd_go & (word_addr == STAT_ADDR);
    assign stat_wr = wr_en & (word_addr == STAT_ADDR);
    assign cfg_wr = wr_en & (word_addr == CFG_ADDR);
    assign cmd_wr = wr_en & (word_addr == CMD_ADDR);
    assign drop_evt = rx_sts_i.valid & ~rx_sts_ready_o;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hold_reg <= '0;
        end else if (wr_go && bus16_reg && !half_hi) begin
            hold_reg <= req_s2.wdata[HALF_W-1:0];
        end
    end

    assign wr_word = bus16_reg ? {req_s2.wdata[HALF_W-1:0], hold_reg} : req_s2.wdata;

    always_comb begin
        stat_word = '0;
        stat_word[STAT_TXOVR_BIT] = txovr_reg;
        stat_word[STAT_RXUND_BIT] = rxund_reg;
        stat_word[STAT_LINK_BIT] = link_ll_reg;
        stat_word[STAT_EVT_BIT] = evt_lh_reg;
        stat_word[STAT_RXS_CNT_LSB +: CNT_W] = rxs_cnt;
        stat_word[STAT_TXD_CNT_LSB +: CNT_W] = txd_cnt;
        stat_word[STAT_DROP_LSB +: DROP_W] = drop_reg;
        cfg_word = '0;
        cfg_word[CFG_SCRATCH_LSB +: CFG_FIELD_W] = scratch_reg;
        cfg_word[CFG_KEEP_LSB +: CFG_FIELD_W] = keep_reg;
        cfg_word[CFG_BUS16_BIT] = bus16_reg;
    end

    always_comb begin
        rd_word = '0;
        if (is_rxd) begin
            rd_word = rxd_valid ? rxd_head : '0;
        end else begin
            unique case (word_addr)
                RXS_POP, RXS_PEEK: rd_word = rxs_valid ? rxs_head : '0;
                TXS_POP, TXS_PEEK: rd_word = txs_valid ? txs_head : '0;
                STAT_ADDR: rd_word = stat_word;
                CFG_ADDR: rd_word = cfg_word;
                default: rd_word = '0;
            endcase
        end
    end

    // Host read data, acknowledge and bus drive.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= '0;
            ack_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= rd_go | wr_go;
            if (rd_go) begin
                if (bus16_reg) begin
                    rdata_reg <= {{HALF_W{1'b0}},
                        half_hi ? rd_word[DATA_W-1:HALF_W] : rd_word[HALF_W-1:0]};
                end else begin
                    rdata_reg <= rd_word;
                end
                drive_reg <= 1'b1;
            end else if (!req_s2.rd) begin
                drive_reg <= 1'b0;
            end
        end
    end

    // Command strobes self-clear after one cycle.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            srst_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else if (ce_i) begin
            srst_reg <= cmd_wr & wr_word[CMD_SRST_BIT];
            flush_reg <= cmd_wr & wr_word[CMD_FLUSH_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
            scratch_reg <= CFG_SCRATCH_RST;
            bus16_reg <= CFG_BUS16_RST;
        end else if (ce_i && cfg_wr) begin
            scratch_reg <= wr_word[CFG_SCRATCH_LSB +: CFG_FIELD_W];
            bus16_reg <= wr_word[CFG_BUS16_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            keep_reg <= CFG_KEEP_RST;
        end else if (ce_i && cfg_wr) begin
            keep_reg <= wr_word[CFG_KEEP_LSB +: CFG_FIELD_W];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
            txovr_reg <= FLAG_RST;
            rxund_reg <= FLAG_RST;
        end else if (ce_i) begin
            if (txd_push && !txd_in_ready) begin
                txovr_reg <= 1'b1;
            end else if (stat_wr && wr_word[STAT_TXOVR_BIT]) begin
                txovr_reg <= 1'b0;
            end
            if ((rxd_pop && !rxd_valid) || (rxs_pop && !rxs_valid) ||
                    (txs_pop && !txs_valid)) begin
                rxund_reg <= 1'b1;
            end else if (stat_wr && wr_word[STAT_RXUND_BIT]) begin
                rxund_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
            link_ll_reg <= LINK_LL_RST;
            evt_lh_reg <= FLAG_RST;
        end else if (ce_i) begin
            if (stat_rd) begin
                link_ll_reg <= link_up_i;
                evt_lh_reg <= mac_event_i;
            end else begin
                if (!link_up_i) begin
                    link_ll_reg <= 1'b0;
                end
                if (mac_event_i) begin
                    evt_lh_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
            drop_reg <= DROP_RST;
        end else if (ce_i) begin
            if (stat_rd) begin
                drop_reg <= {{(DROP_W - 1){1'b0}}, drop_evt};
            end else if (drop_evt && drop_reg != '1) begin
                drop_reg <= drop_reg + 1'b1;
            end
        end
    end

    hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxs_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_all),
        .ce_i(ce_i),
        .flush_i(flush_reg),
        .in_valid_i(rx_sts_i.valid),
        .in_ready_o(rx_sts_ready_o),
        .in_data_i(rx_sts_i.data),
        .out_valid_o(rxs_valid),
        .out_ready_i(rxs_pop),
        .out_data_o(rxs_head),
        .count_o(rxs_cnt)
    );

    hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxd_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_all),
        .ce_i(ce_i),
        .flush_i(flush_reg),
        .in_valid_i(rx_dat_i.valid),
        .in_ready_o(rx_dat_ready_o),
        .in_data_i(rx_dat_i.data),
        .out_valid_o(rxd_valid),
        .out_ready_i(rxd_pop),
        .out_data_o(rxd_head),
        .count_o()
    );

    hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txs_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_all),
        .ce_i(ce_i),
        .flush_i(flush_reg),
        .in_valid_i(tx_sts_i.valid),
        .in_ready_o(tx_sts_ready_o),
        .in_data_i(tx_sts_i.data),
        .out_valid_o(txs_valid),
        .out_ready_i(txs_pop),
        .out_data_o(txs_head),
        .count_o()
    );

    hfpa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txd_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_all),
        .ce_i(ce_i),
        .flush_i(flush_reg),
        .in_valid_i(txd_push),
        .in_ready_o(txd_in_ready),
        .in_data_i(wr_word),
        .out_valid_o(tx_dat_o.valid),
        .out_ready_i(tx_dat_ready_i),
        .out_data_o(tx_dat_o.data),
        .count_o(txd_cnt)
    );

    assign host_rdata_o = rdata_reg;
    assign host_data_oe_n_o = ~drive_reg;
    assign host_ack_o = ack_reg;
    assign host_tx_ready_o = txd_in_ready;
    assign bus16_o = bus16_reg;

endmodule : hfpa_top

/* verification/hfpa_props.sv */
// Concurrent checks on the ports of the host FIFO port access block.
`timescale 1ns/1ps
module hfpa_props
    import hfpa_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [DATA_W-1:0] host_rdata_o,
    input wire logic host_data_oe_n_o,
    input wire logic host_ack_o,
    input wire logic host_tx_ready_o,
    input wire logic bus16_o,
    input wire logic rx_sts_ready_o,
    input wire logic rx_dat_ready_o,
    input wire logic tx_sts_ready_o,
    input wire hfpa_word_t tx_dat_o,
    input wire logic tx_dat_ready_i
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_rst_out;
        $fell(sys_rst_i) |-> !host_ack_o && host_data_oe_n_o && !tx_dat_o.valid && !bus16_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not at reset level");
    property p_rst_rdy;
        $fell(sys_rst_i) |-> rx_sts_ready_o && rx_dat_ready_o && tx_sts_ready_o && host_tx_ready_o;
    endproperty
    a_rst_rdy: assert property (p_rst_rdy) else $error("ready low after reset");
    property p_ack_pulse;
        host_ack_o |=> !host_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_lat;
        ce_i && !host_cs_n_i && (!host_rd_n_i || !host_wr_n_i) && $past(host_cs_n_i)
            |-> !host_ack_o ##1 !host_ack_o ##1 !host_ack_o ##1 host_ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not three cycles after strobe");
    property p_oe_rd;
        host_ack_o && !host_rd_n_i |-> !host_data_oe_n_o;
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("data bus not driven at read ack");
    property p_oe_off;
        host_rd_n_i [*6] |-> host_data_oe_n_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data bus driven without read");
    property p_rdata_hold;
        $changed(host_rdata_o) |-> host_ack_o;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without ack");
    property p_full_valid;
        !host_tx_ready_o |-> tx_dat_o.valid;
    endproperty
    a_full_valid: assert property (p_full_valid) else $error("full tx FIFO shows no head");
    property p_tx_stall;
        host_wr_n_i [*4] ##0 (tx_dat_o.valid && !tx_dat_ready_i)
            |=> tx_dat_o.valid && $stable(tx_dat_o.data);
    endproperty
    a_tx_stall: assert property (p_tx_stall) else $error("tx head moved while stalled");

    c_rd_ack: cover property (host_ack_o && !host_rd_n_i);
    c_tx_full: cover property (!host_tx_ready_o);
    c_rxs_full: cover property (!rx_sts_ready_o);
endmodule : hfpa_props

bind hfpa_top hfpa_props u_props (.core_clk_i, .sys_rst_i, .ce_i, .host_cs_n_i, .host_rd_n_i,
    .host_wr_n_i, .host_rdata_o, .host_data_oe_n_o, .host_ack_o, .host_tx_ready_o, .bus16_o,
    .rx_sts_ready_o, .rx_dat_ready_o, .tx_sts_ready_o, .tx_dat_o, .tx_dat_ready_i);

/* verification/hfpa_host_model.sv */
// Host CPU model that drives the strobe bus of the block.
`timescale 1ns/1ps
module hfpa_host_model
    import hfpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o
);
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 8'hFF;
        wdata_o = 32'h0000_0000;
    end

    // callers hand mapped addresses only, with reserved bits zero.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                        output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= wr;
        wr_n_o <= !wr;
        addr_o <= a;
        wdata_o <= d;
        while (!ok && n < 20) begin
            @(posedge clk_i);
            ok = (ack_i === 1'b1);
            n++;
        end
        q = rdata_i;
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        // Released lines toggle so that no stale value looks valid.
        addr_o <= ~a;
        wdata_o <= ~d;
        repeat (3) @(posedge clk_i);
    endtask : xfer
endmodule : hfpa_host_model

/* verification/host_fifo_port_access_bench.sv */
// Self-checking bench for the host FIFO port access block.
`timescale 1ns/1ps
module host_fifo_port_access_bench
    import hfpa_pkg::*;
;
    logic clk, rst, ce, cs_n, rd_n, wr_n, oe_n, ack, txrdy, b16, link, evt;
    logic rxs_rdy, rxd_rdy, txs_rdy, txd_rdy;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    hfpa_word_t rxs, rxd, txs, txd;
    int err_total, num_checks;

`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, ex, ac); end end

    hfpa_top dut (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .host_cs_n_i(cs_n),
        .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_addr_i(addr), .host_wdata_i(wdata),
        .host_rdata_o(rdata), .host_data_oe_n_o(oe_n), .host_ack_o(ack),
        .host_tx_ready_o(txrdy), .bus16_o(b16), .link_up_i(link), .mac_event_i(evt),
        .rx_sts_i(rxs), .rx_sts_ready_o(rxs_rdy), .rx_dat_i(rxd), .rx_dat_ready_o(rxd_rdy),
        .tx_sts_i(txs), .tx_sts_ready_o(txs_rdy), .tx_dat_o(txd), .tx_dat_ready_i(txd_rdy));
    hfpa_host_model u_host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        u_host.xfer(w, a, d, q, ok);
        if (!ok) begin
            err_total++;
            $display("BAD ack exp 1 got 0");
            close_out();
        end
    endtask : acc

    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic mpush(input int k, input logic [31:0] d);
        @(posedge clk);
        rxs <= {k == 0, d};
        rxd <= {k == 1, d};
        txs <= {k == 2, d};
    endtask : mpush

    task automatic mstop;
        @(posedge clk);
        rxs.valid <= 1'b0;
        rxd.valid <= 1'b0;
        txs.valid <= 1'b0;
    endtask : mstop

    task automatic t_reset;
        `CHK("ack", 1'b0, ack)
        `CHK("oe_n", 1'b1, oe_n)
        `CHK("readies", 5'h1E, {txrdy, rxs_rdy, rxd_rdy, txs_rdy, txd.valid})
        `CHK("bus16", 1'b0, b16)
        rd(STAT_ADDR);
        `CHK("stat", 32'h0000_0000, q)
        rd(CFG_ADDR);
        `CHK("cfg", 32'h0000_0000, q)
        $display("done t_reset");
    endtask : t_reset

    task automatic t_rxs;
        mpush(0, 32'hA000_0001);
        mpush(0, 32'hA000_0002);
        mstop();
        rd(RXS_PEEK);
        `CHK("peek1", 32'hA000_0001, q)
        rd(RXS_PEEK);
        `CHK("peek2", 32'hA000_0001, q)
        wr(STAT_ADDR, 32'hFF1F_1F00);
        rd(STAT_ADDR);
        `CHK("rxs_cnt", 5'h02, q[12:8])
        rd(RXS_POP);
        `CHK("pop1", 32'hA000_0001, q)
        rd(RXS_POP);
        `CHK("pop2", 32'hA000_0002, q)
        rd(RXS_POP);
        `CHK("pop_empty", 32'h0000_0000, q)
        rd(STAT_ADDR);
        `CHK("underrun", 6'h01, {q[12:8], q[1]})
        wr(STAT_ADDR, 32'h0000_0000);
        rd(STAT_ADDR);
        `CHK("w0_keep", 1'b1, q[1])
        wr(STAT_ADDR, 32'h0000_0002);
        rd(STAT_ADDR);
        `CHK("w1_clear", 1'b0, q[1])
        $display("done t_rxs");
    endtask : t_rxs

    task automatic t_rxd;
        for (int i = 0; i < 8; i++) begin
            mpush(1, 32'hD000_0000 + i);
        end
        mstop();
        wr(RXD_BASE + 8'h04, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            rd(RXD_BASE + 8'(4 * i));
            `CHK("rxd", 32'hD000_0000 + i, q)
        end
        $display("done t_rxd");
    endtask : t_rxd

    task automatic t_tx;
        for (int i = 0; i < 16; i++) begin
            wr(TXD_BASE + 8'(4 * (i % 8)), 32'hC000_0000 + i);
        end
        `CHK("tx_ready", 1'b0, txrdy)
        wr(TXD_BASE, 32'hDEAD_0000);
        rd(STAT_ADDR);
        `CHK("tx_cnt", 6'h21, {q[20:16], q[0]})
        rd(TXD_BASE + 8'h04);
        `CHK("txd_rd", 32'h0000_0000, q)
        rd(CMD_ADDR);
        `CHK("cmd_rd", 32'h0000_0000, q)
        @(posedge clk);
        txd_rdy <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            `CHK("txd", {1'b1, 32'hC000_0000 + i}, txd)
        end
        @(posedge clk);
        txd_rdy <= 1'b0;
        @(negedge clk);
        `CHK("txd_empty", 1'b0, txd.valid)
        wr(STAT_ADDR, 32'h0000_0001);
        rd(STAT_ADDR);
        `CHK("overrun_clr", 1'b0, q[0])
        $display("done t_tx");
    endtask : t_tx

    task automatic t_txs;
        mpush(2, 32'hB000_0001);
        mpush(2, 32'hB000_0002);
        mstop();
        rd(TXS_PEEK);
        rd(TXS_PEEK);
        `CHK("tpeek", 32'hB000_0001, q)
        rd(TXS_POP);
        `CHK("tpop1", 32'hB000_0001, q)
        rd(TXS_POP);
        `CHK("tpop2", 32'hB000_0002, q)
        rd(TXS_POP);
        `CHK("tpop_empty", 32'h0000_0000, q)
        $display("done t_txs");
    endtask : t_txs

    task automatic t_latch;
        @(posedge clk);
        link <= 1'b1;
        rd(STAT_ADDR);
        rd(STAT_ADDR);
        `CHK("link_up", 2'b01, q[3:2])
        @(posedge clk);
        link <= 1'b0;
        evt <= 1'b1;
        @(posedge clk);
        link <= 1'b1;
        evt <= 1'b0;
        rd(STAT_ADDR);
        `CHK("latched", 2'b10, q[3:2])
        rd(STAT_ADDR);
        `CHK("released", 2'b01, q[3:2])
        for (int i = 0; i < 17; i++) begin
            mpush(0, i);
        end
        mstop();
        `CHK("rxs_full", 1'b0, rxs_rdy)
        rd(STAT_ADDR);
        `CHK("drop", 13'h0030, {q[31:24], q[12:8]})
        rd(STAT_ADDR);
        `CHK("drop_clr", 8'h00, q[31:24])
        $display("done t_latch");
    endtask : t_latch

    task automatic t_srst;
        wr(CFG_ADDR, 32'h0000_A55A);
        rd(CFG_ADDR);
        `CHK("cfg_rw", 32'h0000_A55A, q)
        wr(CMD_ADDR, 32'h0000_0002);
        @(posedge clk);
        ce <= 1'b0;
        mpush(0, 32'h5A5A_0001);
        @(posedge clk);
        ce <= 1'b1;
        mstop();
        rd(RXS_PEEK);
        `CHK("frozen_push", 32'h5A5A_0001, q)
        rd(STAT_ADDR);
        `CHK("flush_cnt", 6'h21, {rxs_rdy, q[12:8]})
        wr(CMD_ADDR, 32'h0000_0001);
        rd(CFG_ADDR);
        `CHK("cfg_srst", 32'h0000_A500, q)
        rd(STAT_ADDR);
        `CHK("flushed", 7'h40, {rxs_rdy, q[12:8], q[1]})
        $display("done t_srst");
    endtask : t_srst

    task automatic t_b16;
        wr(CFG_ADDR, 32'h0001_0000);
        `CHK("bus16_on", 1'b1, b16)
        mpush(1, 32'h1234_5678);
        mpush(1, 32'h9ABC_DEF0);
        mstop();
        rd(RXD_BASE);
        `CHK("lo0", 16'h5678, q[15:0])
        rd(RXD_BASE + 8'h02);
        `CHK("hi0", 16'h1234, q[15:0])
        rd(RXD_BASE + 8'h1C);
        `CHK("lo1", 16'hDEF0, q[15:0])
        rd(RXD_BASE + 8'h1E);
        `CHK("hi1", 16'h9ABC, q[15:0])
        wr(CFG_ADDR, 32'h0000_0000);
        wr(CFG_ADDR + 8'h02, 32'h0000_0000);
        `CHK("bus16_off", 1'b0, b16)
        $display("done t_b16");
    endtask : t_b16

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        link = 1'b0;
        evt = 1'b0;
        rxs = '0;
        rxd = '0;
        txs = '0;
        txd_rdy = 1'b0;
        err_total = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_rxs();
        t_rxd();
        t_tx();
        t_txs();
        t_latch();
        t_srst();
        t_b16();
        close_out();
    end
endmodule : host_fifo_port_access_bench
